// [pkg/bfc_defines.vh]
// Constants for the burst-mode flash front end
`ifndef BFC_DEFINES_VH
`define BFC_DEFINES_VH
`define BFC_AW         19
`define BFC_DW         16
`define BFC_CW         8
`define BFC_BYTE       8
`define BFC_BL         5
`define BFC_NSEC       9
`define BFC_SECW       4
`define BFC_SEC_END    4'h9
`define BFC_SEC0_BASE  19'h00000
`define BFC_SEC1_BASE  19'h02000
`define BFC_SEC2_BASE  19'h03000
`define BFC_SEC3_BASE  19'h04000
`define BFC_SEC4_BASE  19'h10000
`define BFC_SEC5_BASE  19'h20000
`define BFC_SEC6_BASE  19'h30000
`define BFC_SEC7_BASE  19'h40000
`define BFC_SEC8_BASE  19'h60000
`define BFC_TOP        19'h7FFFF
`define BFC_DEPTH      524288
`define BFC_ERASED     16'hFFFF
`define BFC_PROGRAMMED 16'h0000
`define BFC_UL_MASK    19'h007FF
`define BFC_UL1_ADDR   19'h00555
`define BFC_UL2_ADDR   19'h002AA
`define BFC_CMD_UL1    8'hAA
`define BFC_CMD_UL2    8'h55
`define BFC_CMD_PROG   8'hA0
`define BFC_CMD_ESET   8'h80
`define BFC_CMD_CHIP   8'h10
`define BFC_CMD_SECT   8'h30
`define BFC_CMD_RESUME 8'h30
`define BFC_CMD_SUSP   8'hB0
`define BFC_CMD_RESET  8'hF0
`define BFC_CMD_BYP    8'h20
`define BFC_CMD_BYPR   8'h90
`define BFC_CMD_BYPX   8'h00
`define BFC_CMD_BON    8'hC0
`define BFC_CMD_BOFF   8'hC1
`define BFC_POLL_BIT   7
`define BFC_TOG_BIT    6
`define BFC_REG_CTRL   8'h00
`define BFC_REG_PROT   8'h04
`define BFC_REG_STAT   8'h08
`define BFC_CTRL_TUNP  0
`define BFC_TUNP_RST   1'b0
`define BFC_PROT_RST   9'h000
`define BFC_ST_BUSY    0
`define BFC_ST_SUSP    1
`define BFC_ST_BURST   2
`define BFC_ST_BYP     3
`define BFC_ST_SLEEP   4
`define BFC_ST_STBY    5
`define BFC_ST_PFAIL   6
`define BFC_ST_EMASK   8
`define BFC_CLK_NS     20
`define BFC_PROG_NS    400
`define BFC_ERASE_NS   4000
`define BFC_SEWIN_NS   2000
`define BFC_SLEEP_NS   300
`define BFC_PROG_TRIES 4'h8
`define BFC_CNTW       16
`define BFC_CNT_ZERO   16'h0000
`endif

// [design/bfc_sync.v]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module bfc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         srst_i,
  // Raw and synchronised levels
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage is read by the second stage only
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// [design/bfc_array.v]
// Word array with one write port and two read ports
`timescale 1ns/1ps
`include "bfc_defines.vh"
module bfc_array (
  // Clock
  input  wire                clk_i,
  // Write port
  input  wire                we_i,
  input  wire [`BFC_AW-1:0]  waddr_i,
  input  wire [`BFC_DW-1:0]  wdata_i,
  // Host read port
  input  wire [`BFC_AW-1:0]  raddr_a_i,
  output wire [`BFC_DW-1:0]  rdata_a_o,
  // Engine verify port
  input  wire [`BFC_AW-1:0]  raddr_b_i,
  output wire [`BFC_DW-1:0]  rdata_b_o
);
  reg [`BFC_DW-1:0] mem [0:`BFC_DEPTH-1];
  integer k;

  // Shipped fully erased
  initial begin
    for (k = 0; k < `BFC_DEPTH; k = k + 1) begin
      mem[k] = `BFC_ERASED;
    end
  end

  // Whole-word writes only
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_a_o = mem[raddr_a_i];
  assign rdata_b_o = mem[raddr_b_i];
endmodule

// [design/bfc_flash.v]
// Burst flash front end: pins, command sequencer, engines, registers
`timescale 1ns/1ps
`include "bfc_defines.vh"
module bfc_flash (
  // Clock and reset
  input  wire                sys_clk_i,
  input  wire                srst_i,
  // Asynchronous bus pins
  input  wire                ce_n_i,
  input  wire                we_n_i,
  input  wire                oe_n_i,
  input  wire [`BFC_AW-1:0]  addr_i,
  input  wire [`BFC_DW-1:0]  dq_i,
  output wire [`BFC_DW-1:0]  dq_o,
  output wire                dq_oe_n_o,
  // Burst pins
  input  wire                burst_load_strobe_n_i,
  input  wire                burst_advance_n_i,
  input  wire                burst_clk_i,
  // Reset pin and status pins
  input  wire                hw_reset_n_i,
  output wire                done_pending_n_o,
  output wire                sleep_o,
  output wire                standby_o,
  // Wishbone slave
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [7:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output wire [31:0]         wb_dat_o,
  output wire                wb_ack_o
);
  localparam [3:0] C_RD = 4'h0, C_U1 = 4'h1, C_U2 = 4'h2, C_ESET = 4'h3;
  localparam [3:0] C_EU1 = 4'h4, C_EU2 = 4'h5, C_PROG = 4'h6;
  localparam [3:0] C_SEWIN = 4'h7, C_BYP = 4'h8, C_BYPX = 4'h9;
  localparam [1:0] P_IDLE = 2'h0, P_WR = 2'h1, P_VER = 2'h2;
  localparam [2:0] E_IDLE = 3'h0, E_NEXT = 3'h1, E_PRE = 3'h2;
  localparam [2:0] E_PULSE = 3'h3, E_ERS = 3'h4, E_VER = 3'h5;
  localparam integer PROG_CYC =
    (`BFC_PROG_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
  localparam integer ERASE_CYC =
    (`BFC_ERASE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
  localparam integer SEWIN_CYC =
    (`BFC_SEWIN_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
  localparam integer SLEEP_CYC =
    (`BFC_SLEEP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
  localparam [`BFC_CNTW-1:0] PROG_LIM  = PROG_CYC[`BFC_CNTW-1:0];
  localparam [`BFC_CNTW-1:0] ERASE_LIM = ERASE_CYC[`BFC_CNTW-1:0];
  localparam [`BFC_CNTW-1:0] SEWIN_LIM = SEWIN_CYC[`BFC_CNTW-1:0];
  localparam [`BFC_CNTW-1:0] SLEEP_LIM = SLEEP_CYC[`BFC_CNTW-1:0];
  localparam [`BFC_NSEC-1:0] ALL_SEC   = {`BFC_NSEC{1'b1}};

  // Sector index of a word address
  function [`BFC_SECW-1:0] sec_of;
    input [`BFC_AW-1:0] a;
    begin
      if (a >= `BFC_SEC8_BASE) sec_of = 4'h8;
      else if (a >= `BFC_SEC7_BASE) sec_of = 4'h7;
      else if (a >= `BFC_SEC6_BASE) sec_of = 4'h6;
      else if (a >= `BFC_SEC5_BASE) sec_of = 4'h5;
      else if (a >= `BFC_SEC4_BASE) sec_of = 4'h4;
      else if (a >= `BFC_SEC3_BASE) sec_of = 4'h3;
      else if (a >= `BFC_SEC2_BASE) sec_of = 4'h2;
      else if (a >= `BFC_SEC1_BASE) sec_of = 4'h1;
      else sec_of = 4'h0;
    end
  endfunction

  // First word of a sector
  function [`BFC_AW-1:0] sec_base;
    input [`BFC_SECW-1:0] s;
    begin
      case (s)
        4'h1: sec_base = `BFC_SEC1_BASE;
        4'h2: sec_base = `BFC_SEC2_BASE;
        4'h3: sec_base = `BFC_SEC3_BASE;
        4'h4: sec_base = `BFC_SEC4_BASE;
        4'h5: sec_base = `BFC_SEC5_BASE;
        4'h6: sec_base = `BFC_SEC6_BASE;
        4'h7: sec_base = `BFC_SEC7_BASE;
        4'h8: sec_base = `BFC_SEC8_BASE;
        default: sec_base = `BFC_SEC0_BASE;
      endcase
    end
  endfunction

  // Last word of a sector
  function [`BFC_AW-1:0] sec_last;
    input [`BFC_SECW-1:0] s;
    begin
      if (s == 4'h8) sec_last = `BFC_TOP;
      else sec_last = sec_base(s + 4'h1) - 19'h00001;
    end
  endfunction

  // Byte enables widened to a bit mask
  function [31:0] lane_mask;
    input [3:0] s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        lane_mask[k*`BFC_BYTE +: `BFC_BYTE] = {`BFC_BYTE{s[k]}};
      end
    end
  endfunction

  wire [`BFC_AW-1:0] addr_s;
  wire [`BFC_DW-1:0] dq_s;
  wire ce_n_s, we_n_s, oe_n_s, lba_n_s, baa_n_s, bclk_s, hwr_n_s;
  wire [`BFC_DW-1:0] rd_a, rd_b;
  reg  [`BFC_AW-1:0] addr_q, burst_addr_r, cmd_addr_r, pg_addr_r, e_addr;
  reg  [`BFC_DW-1:0] cmd_data_r, pg_data_r, dq_r, sts, mem_wd;
  reg  [`BFC_NSEC-1:0] er_mask_r, sel_r, prot_r;
  reg  [`BFC_CNTW-1:0] sw_cnt_r, p_cnt, e_cnt, slp_cnt_r;
  reg  [`BFC_SECW-1:0] e_sec;
  reg  [3:0] c_st, p_try;
  reg  [2:0] e_st;
  reg  [1:0] p_st;
  reg  we_q, oe_q, bclk_q, cmd_vld_r, byp_r, burst_r, susp_r;
  reg  pg_go_r, er_go_r, pfail_r, tog_r, sleep_r, stby_r, dq_oe_n_r;
  reg  tunp_r, ack_r, mem_we;
  reg  [31:0] wb_dat_r, reg_rd;
  reg  [`BFC_AW-1:0] mem_wa;

  // All pins pass two flops before use
  bfc_sync #(.W(`BFC_AW + `BFC_DW + 7)) u_sync (
    .clk_i  (sys_clk_i),
    .srst_i (srst_i),
    .d_i    ({hw_reset_n_i, burst_clk_i, burst_advance_n_i,
              burst_load_strobe_n_i, oe_n_i, we_n_i, ce_n_i, dq_i,
              addr_i}),
    .q_o    ({hwr_n_s, bclk_s, baa_n_s, lba_n_s, oe_n_s, we_n_s, ce_n_s,
              dq_s, addr_s})
  );

  wire hw_rst    = srst_i | ~hwr_n_s;
  wire wr_evt    = ~ce_n_s & we_n_s & ~we_q;
  wire rd_en     = ~ce_n_s & ~oe_n_s & we_n_s;
  wire rd_start  = rd_en & oe_q;
  wire bclk_rise = bclk_s & ~bclk_q;
  wire p_busy    = p_st != P_IDLE;
  wire er_run    = e_st != E_IDLE;
  wire e_hold    = susp_r | p_busy;
  wire [`BFC_CW-1:0] code = cmd_data_r[`BFC_CW-1:0];
  wire ul1 = ((cmd_addr_r & `BFC_UL_MASK) == `BFC_UL1_ADDR) &
             (code == `BFC_CMD_UL1);
  wire ul2 = ((cmd_addr_r & `BFC_UL_MASK) == `BFC_UL2_ADDR) &
             (code == `BFC_CMD_UL2);
  wire [`BFC_SECW-1:0] csec = sec_of(cmd_addr_r);
  wire [`BFC_NSEC-1:0] allow = tunp_r ? ALL_SEC : ~prot_r;
  wire [3:0] c_home = byp_r ? C_BYP : C_RD;

  // Pin edge history
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      we_q   <= 1'b1;
      oe_q   <= 1'b1;
      bclk_q <= 1'b1;                      // Sync resets high: no false rise
      addr_q <= `BFC_SEC0_BASE;
    end else begin
      we_q   <= we_n_s;
      oe_q   <= oe_n_s | ce_n_s;
      bclk_q <= bclk_s;
      addr_q <= addr_s;
    end
  end

  // Latch address and data of every write cycle
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      cmd_vld_r  <= 1'b0;
      cmd_addr_r <= `BFC_SEC0_BASE;
      cmd_data_r <= `BFC_PROGRAMMED;
    end else begin
      cmd_vld_r <= wr_evt;
      if (wr_evt) begin
        cmd_addr_r <= addr_s;
        cmd_data_r <= dq_s;
      end
    end
  end

  // Command sequencer; busy program ignores all writes
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      c_st      <= C_RD;
      byp_r     <= 1'b0;
      burst_r   <= 1'b0;
      susp_r    <= 1'b0;
      pg_go_r   <= 1'b0;
      er_go_r   <= 1'b0;
      sel_r     <= {`BFC_NSEC{1'b0}};
      er_mask_r <= {`BFC_NSEC{1'b0}};
      sw_cnt_r  <= `BFC_CNT_ZERO;
      pg_addr_r <= `BFC_SEC0_BASE;
      pg_data_r <= `BFC_ERASED;
    end else begin
      pg_go_r <= 1'b0;
      er_go_r <= 1'b0;
      if (!er_run && !er_go_r) susp_r <= 1'b0;
      if (c_st == C_SEWIN && !cmd_vld_r) begin
        sw_cnt_r <= sw_cnt_r + 1'b1;
        if (sw_cnt_r == SEWIN_LIM) begin
          c_st      <= C_RD;
          er_mask_r <= sel_r & allow;
          er_go_r   <= |(sel_r & allow);
        end
      end else if (cmd_vld_r && !p_busy) begin
        if (er_run && !susp_r) begin
          if (code == `BFC_CMD_SUSP) susp_r <= 1'b1;
        end else begin
          case (c_st)
            C_RD: begin
              if (ul1) c_st <= C_U1;
              else if (susp_r && code == `BFC_CMD_RESUME)
                susp_r <= 1'b0;
            end
            C_U1: c_st <= ul2 ? C_U2 : c_home;
            C_U2: begin
              c_st <= c_home;
              if (code == `BFC_CMD_PROG) c_st <= C_PROG;
              else if (code == `BFC_CMD_ESET && !susp_r) c_st <= C_ESET;
              else if (code == `BFC_CMD_BYP && !susp_r) begin
                byp_r <= 1'b1;
                c_st  <= C_BYP;
              end else if (code == `BFC_CMD_BON) burst_r <= 1'b1;
              else if (code == `BFC_CMD_BOFF) burst_r <= 1'b0;
            end
            C_ESET: c_st <= ul1 ? C_EU1 : C_RD;
            C_EU1: c_st <= ul2 ? C_EU2 : C_RD;
            C_EU2: begin
              c_st <= C_RD;
              if (code == `BFC_CMD_CHIP) begin
                er_mask_r <= allow;
                er_go_r   <= |allow;
              end else if (code == `BFC_CMD_SECT) begin
                sel_r    <= {`BFC_NSEC{1'b0}} | (9'h001 << csec);
                sw_cnt_r <= `BFC_CNT_ZERO;
                c_st     <= C_SEWIN;
              end
            end
            C_SEWIN: begin
              if (code == `BFC_CMD_SECT) begin
                sel_r    <= sel_r | (9'h001 << csec);
                sw_cnt_r <= `BFC_CNT_ZERO;
              end else begin
                c_st <= C_RD;
              end
            end
            C_PROG: begin
              c_st <= c_home;
              if (allow[csec] && !(susp_r && er_mask_r[csec])) begin
                pg_go_r   <= 1'b1;
                pg_addr_r <= cmd_addr_r;
                pg_data_r <= cmd_data_r;
              end
            end
            C_BYP: begin
              if (code == `BFC_CMD_PROG) c_st <= C_PROG;
              else if (code == `BFC_CMD_BYPR) c_st <= C_BYPX;
            end
            C_BYPX: begin
              c_st <= C_BYP;
              if (code == `BFC_CMD_BYPX) begin
                byp_r <= 1'b0;
                c_st  <= C_RD;
              end
            end
            default: c_st <= C_RD;
          endcase
        end
      end
    end
  end

  // Program engine: write, wait, verify, bounded retries
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      p_st    <= P_IDLE;
      p_cnt   <= `BFC_CNT_ZERO;
      p_try   <= 4'h0;
      pfail_r <= 1'b0;
    end else begin
      case (p_st)
        P_IDLE: begin
          if (pg_go_r) begin
            p_st    <= P_WR;
            p_cnt   <= `BFC_CNT_ZERO;
            p_try   <= 4'h0;
            pfail_r <= 1'b0;
          end
        end
        P_WR: begin
          if (p_cnt == PROG_LIM) p_st <= P_VER;
          else p_cnt <= p_cnt + 1'b1;
        end
        P_VER: begin
          if (rd_b == pg_data_r) p_st <= P_IDLE;
          else if (p_try == `BFC_PROG_TRIES) begin
            pfail_r <= 1'b1;                         // 1 bits cannot be set
            p_st    <= P_IDLE;
          end else begin
            p_try <= p_try + 1'b1;
            p_cnt <= `BFC_CNT_ZERO;
            p_st  <= P_WR;
          end
        end
        default: p_st <= P_IDLE;
      endcase
    end
  end

  // Erase engine walks each selected sector; frozen while held
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      e_st   <= E_IDLE;
      e_sec  <= 4'h0;
      e_addr <= `BFC_SEC0_BASE;
      e_cnt  <= `BFC_CNT_ZERO;
    end else if (e_st == E_IDLE) begin
      if (er_go_r) begin
        e_sec <= 4'h0;
        e_st  <= E_NEXT;
      end
    end else if (!e_hold) begin
      case (e_st)
        E_NEXT: begin
          if (e_sec == `BFC_SEC_END) e_st <= E_IDLE;
          else if (er_mask_r[e_sec]) begin
            e_addr <= sec_base(e_sec);
            e_st   <= E_PRE;
          end else e_sec <= e_sec + 1'b1;
        end
        E_PRE: begin
          e_addr <= e_addr + 1'b1;
          if (e_addr == sec_last(e_sec)) begin
            e_cnt <= `BFC_CNT_ZERO;
            e_st  <= E_PULSE;
          end
        end
        E_PULSE: begin
          e_cnt <= e_cnt + 1'b1;
          if (e_cnt == ERASE_LIM) begin
            e_addr <= sec_base(e_sec);
            e_st   <= E_ERS;
          end
        end
        E_ERS: begin
          e_addr <= e_addr + 1'b1;
          if (e_addr == sec_last(e_sec)) begin
            e_addr <= sec_base(e_sec);
            e_st   <= E_VER;
          end
        end
        E_VER: begin
          e_addr <= e_addr + 1'b1;
          if (rd_b != `BFC_ERASED) begin
            e_cnt <= `BFC_CNT_ZERO;
            e_st  <= E_PULSE;
          end else if (e_addr == sec_last(e_sec)) begin
            e_sec <= e_sec + 1'b1;
            e_st  <= E_NEXT;
          end
        end
        default: e_st <= E_IDLE;
      endcase
    end
  end

  // Write port: program first, erase only inside its own sector
  always @* begin
    mem_we = 1'b0;
    mem_wa = e_addr;
    mem_wd = `BFC_ERASED;
    if (p_st == P_WR && p_cnt == `BFC_CNT_ZERO) begin
      mem_we = 1'b1;
      mem_wa = pg_addr_r;
      mem_wd = rd_b & pg_data_r;
    end else if (!e_hold && e_st == E_PRE && rd_b != `BFC_PROGRAMMED) begin
      mem_we = 1'b1;
      mem_wd = `BFC_PROGRAMMED;
    end else if (!e_hold && e_st == E_ERS) begin
      mem_we = 1'b1;
    end
  end

  // Burst address: load, then step the low bits with wrap
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      burst_addr_r <= `BFC_SEC0_BASE;
    end else if (burst_r && bclk_rise && !ce_n_s) begin
      if (!lba_n_s) burst_addr_r <= addr_s;
      else if (!baa_n_s)
        burst_addr_r[`BFC_BL-1:0] <=
          burst_addr_r[`BFC_BL-1:0] + 1'b1;
    end
  end

  wire [`BFC_AW-1:0] ra = burst_r ? burst_addr_r : addr_s;
  wire [`BFC_SECW-1:0] rsec = sec_of(ra);
  wire hit_p   = p_busy & (rsec == sec_of(pg_addr_r));
  wire hit_e   = er_run & er_mask_r[rsec];
  wire stat_rd = hit_p | hit_e;

  // Status word: inverted data bit while programming
  always @* begin
    sts = `BFC_PROGRAMMED;
    sts[`BFC_TOG_BIT] = tog_r;
    if (hit_p) sts[`BFC_POLL_BIT] = ~pg_data_r[`BFC_POLL_BIT];
    else sts[`BFC_POLL_BIT] = susp_r;
  end

  // Read data, toggle bit, sleep and standby
  always @(posedge sys_clk_i) begin
    if (hw_rst) begin
      dq_r      <= `BFC_PROGRAMMED;
      dq_oe_n_r <= 1'b1;
      tog_r     <= 1'b0;
      slp_cnt_r <= `BFC_CNT_ZERO;
      sleep_r   <= 1'b0;
      stby_r    <= 1'b1;
    end else begin
      dq_oe_n_r <= ~rd_en;
      stby_r    <= ce_n_s;
      if (rd_start && (hit_p || (hit_e && !susp_r)))
        tog_r <= ~tog_r;
      // Stable address needs no sense activity; status keeps polling
      if (addr_s != addr_q || rd_start || (burst_r && bclk_rise)) begin
        slp_cnt_r <= `BFC_CNT_ZERO;
        sleep_r   <= 1'b0;
      end else if (slp_cnt_r == SLEEP_LIM) begin
        sleep_r <= 1'b1;
      end else begin
        slp_cnt_r <= slp_cnt_r + 1'b1;
      end
      if (rd_en && (!sleep_r || stat_rd))
        dq_r <= stat_rd ? sts : rd_a;
    end
  end

  bfc_array u_array (
    .clk_i     (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_wa),
    .wdata_i   (mem_wd),
    .raddr_a_i (ra),
    .rdata_a_o (rd_a),
    .raddr_b_i (p_busy ? pg_addr_r : e_addr),
    .rdata_b_o (rd_b)
  );

  // Wishbone: ack one cycle after request, write at acked edge
  wire        wb_req = wb_cyc_i & wb_stb_i;
  wire [31:0] wmask  = lane_mask(wb_sel_i);
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_r    <= 1'b0;
      wb_dat_r <= 32'h00000000;
      tunp_r   <= `BFC_TUNP_RST;
      prot_r   <= `BFC_PROT_RST;
    end else begin
      ack_r <= wb_req & ~ack_r;
      if (wb_req && !ack_r) wb_dat_r <= reg_rd;
      if (wb_req && ack_r && wb_we_i) begin
        if (wb_adr_i == `BFC_REG_CTRL && wmask[`BFC_CTRL_TUNP])
          tunp_r <= wb_dat_i[`BFC_CTRL_TUNP];
        if (wb_adr_i == `BFC_REG_PROT)
          prot_r <= (prot_r & ~wmask[`BFC_NSEC-1:0]) |
                    (wb_dat_i[`BFC_NSEC-1:0] & wmask[`BFC_NSEC-1:0]);
      end
    end
  end

  // Register read mux; unmapped reads as zero
  always @* begin
    reg_rd = 32'h00000000;
    case (wb_adr_i)
      `BFC_REG_CTRL: reg_rd[`BFC_CTRL_TUNP] = tunp_r;
      `BFC_REG_PROT: reg_rd[`BFC_NSEC-1:0] = prot_r;
      `BFC_REG_STAT: begin
        reg_rd[`BFC_ST_BUSY]  = ~done_pending_n_o;
        reg_rd[`BFC_ST_SUSP]  = susp_r;
        reg_rd[`BFC_ST_BURST] = burst_r;
        reg_rd[`BFC_ST_BYP]   = byp_r;
        reg_rd[`BFC_ST_SLEEP] = sleep_r;
        reg_rd[`BFC_ST_STBY]  = stby_r;
        reg_rd[`BFC_ST_PFAIL] = pfail_r;
        reg_rd[`BFC_ST_EMASK +: `BFC_NSEC] = er_mask_r;
      end
      default: reg_rd = 32'h00000000;
    endcase
  end

  assign dq_o      = dq_r;
  assign dq_oe_n_o = dq_oe_n_r;
  assign done_pending_n_o = ~(p_busy | (er_run & ~susp_r));
  assign sleep_o   = sleep_r;
  assign standby_o = stby_r;
  assign wb_dat_o  = wb_dat_r;
  assign wb_ack_o  = ack_r;
endmodule

// [testbench/bfc_flash_asserts.sv]
// Port checker for the burst flash front end
`timescale 1ns/1ps
module bfc_chk (
  // Clock and reset
  input logic        sys_clk_i,
  input logic        srst_i,
  // Flash pins
  input logic        ce_n_i,
  input logic        oe_n_i,
  input logic        hw_reset_n_i,
  input logic [18:0] addr_i,
  input logic        dq_oe_n_o,
  input logic        done_pending_n_o,
  input logic        sleep_o,
  input logic        standby_o,
  // Wishbone
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Bus answers exactly one cycle after a taken request
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property ($rose(wb_ack_o) |=> $fell(wb_ack_o))
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Pin paths pass two sync flops, so five cycles is ample
  oe_gate_a: assert property (oe_n_i [*5] |-> dq_oe_n_o)
    else $error("data driven with output strobe off");
  ce_gate_a: assert property (ce_n_i [*5] |-> dq_oe_n_o)
    else $error("data driven with chip deselected");
  stby_a: assert property (ce_n_i [*5] |-> standby_o)
    else $error("no standby while deselected");
  hwrst_a: assert property ((!hw_reset_n_i) [*5] |-> done_pending_n_o)
    else $error("busy held through hardware reset");
  wake_a: assert property ($changed(addr_i) |-> ##[1:4] !sleep_o)
    else $error("no wake on address change");
  cover property (wb_ack_o);
  cover property (!dq_oe_n_o);
  cover property (!done_pending_n_o);
endmodule
bind bfc_flash bfc_chk bfc_chk_inst (.sys_clk_i, .srst_i, .ce_n_i,
  .oe_n_i, .hw_reset_n_i, .addr_i, .dq_oe_n_o, .done_pending_n_o,
  .sleep_o, .standby_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// [testbench/bfc_host.sv]
// Host bus model driving the flash pins
`timescale 1ns/1ps
module bfc_host (
  // Clock and read data
  input  logic        sys_clk_i,
  input  logic [15:0] rd_i,
  // Flash pins
  output logic        ce_n_o = 1'b1,
  output logic        we_n_o = 1'b1,
  output logic        oe_n_o = 1'b1,
  output logic [18:0] addr_o = 19'h00000,
  output logic [15:0] dq_o = 16'h0000,
  // Burst pins
  output logic        bl_n_o = 1'b1,
  output logic        ba_n_o = 1'b1,
  output logic        bclk_o = 1'b0
);
  // Command write, address and data held well past the strobe
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    repeat (3) @(posedge sys_clk_i);
    addr_o <= a;
    dq_o <= d;
    ce_n_o <= 1'b0;
    we_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    we_n_o <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    ce_n_o <= 1'b1;
    dq_o <= ~d; // Released bus shows no stale word
  endtask
  // Array read, held until synced data has landed
  task automatic rd(input logic [18:0] a, output logic [15:0] q);
    repeat (3) @(posedge sys_clk_i);
    addr_o <= a;
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    q = rd_i;
    ce_n_o <= 1'b1;
    oe_n_o <= 1'b1;
  endtask
  // Burst: load on first clock rise, n advances, clock stops after
  task automatic burst(input logic [18:0] a, input int n,
                       output logic [15:0] q);
    repeat (3) @(posedge sys_clk_i);
    addr_o <= a;
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    bl_n_o <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (4) @(posedge sys_clk_i);
      bclk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      bclk_o <= 1'b0;
      bl_n_o <= 1'b1;
      ba_n_o <= (i == n);
    end
    repeat (6) @(posedge sys_clk_i);
    q = rd_i;
    ce_n_o <= 1'b1;
    oe_n_o <= 1'b1;
  endtask
endmodule

// [testbench/bfc_flash_tb.sv]
// Self-checking bench for the burst flash front end
`timescale 1ns/1ps
module bfc_flash_tb;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, hw_n = 1'b1;
  logic ce_n, we_n, oe_n, busy_n, ack, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic bl_n, ba_n, bclk;
  logic [18:0] addr;
  logic [15:0] dq, rdq, d, e;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  int fails = 0, tests_run = 0, ncyc = 0;
  bfc_host bfc_host_inst (.sys_clk_i, .rd_i(rdq), .ce_n_o(ce_n),
    .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(addr), .dq_o(dq), .bl_n_o(bl_n),
    .ba_n_o(ba_n), .bclk_o(bclk));
  bfc_flash bfc_flash_inst (.sys_clk_i, .srst_i, .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .dq_i(dq), .dq_o(rdq),
    .dq_oe_n_o(), .burst_load_strobe_n_i(bl_n), .burst_advance_n_i(ba_n),
    .burst_clk_i(bclk), .hw_reset_n_i(hw_n), .done_pending_n_o(busy_n),
    .sleep_o(), .standby_o(), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  // Run ceiling; the small sector erase alone needs about 13000
  always @(posedge sys_clk_i) begin
    ncyc <= ncyc + 1;
    if (ncyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Classic cycle held until ack; timeout covers a dead slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge sys_clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Two unlock writes, then command c at address a
  task automatic ul(input logic [18:0] a, input logic [15:0] c);
    bfc_host_inst.wr(19'h00555, 16'h00AA);
    bfc_host_inst.wr(19'h002AA, 16'h0055);
    bfc_host_inst.wr(a, c);
  endtask
  task automatic prog(input logic [18:0] a, input logic [15:0] v);
    ul(19'h00555, 16'h00A0);
    bfc_host_inst.wr(a, v);
  endtask
  task automatic idle();
    while (busy_n !== 1'b1) @(posedge sys_clk_i);
  endtask
  // Program: busy pin, polled status, then stored word
  task automatic t_prog();
    prog(19'h03010, 16'h1234);
    chk(busy_n, 1'b0);
    bfc_host_inst.rd(19'h03010, d);
    chk(d[7], 1'b1);
    idle();
    bfc_host_inst.rd(19'h03010, d);
    chk(d, 16'h1234);
  endtask
  // Protection blocks a sector until unprotect is set
  task automatic t_prot();
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h04, 32'h4);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h4);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    prog(19'h03020, 16'h00A5);
    idle();
    bfc_host_inst.rd(19'h03020, d);
    chk(d, 16'hFFFF);
    wb(1'b1, 8'h00, 32'h1);
    prog(19'h03020, 16'h00A5);
    idle();
    bfc_host_inst.rd(19'h03020, d);
    chk(d, 16'h00A5);
  endtask
  // Reset pin mid-program frees busy and restores reads
  task automatic t_hwrst();
    prog(19'h04040, 16'h0F0F);
    hw_n <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    chk(busy_n, 1'b1);
    hw_n <= 1'b1;
    bfc_host_inst.rd(19'h00000, d);
    chk(d, 16'hFFFF);
  endtask
  // Sector erase: status, suspend, resume, neighbour sector kept
  task automatic t_erase();
    prog(19'h02000, 16'h5A5A);
    idle();
    ul(19'h00555, 16'h0080);
    ul(19'h03000, 16'h0030);
    repeat (110) @(posedge sys_clk_i);
    chk(busy_n, 1'b0);
    bfc_host_inst.rd(19'h03FF0, d);
    bfc_host_inst.rd(19'h03FF0, e);
    chk(d[7], 1'b0);
    chk(e[6], !d[6]);
    bfc_host_inst.wr(19'h00000, 16'h00B0);
    chk(busy_n, 1'b1);
    bfc_host_inst.rd(19'h02000, d);
    chk(d, 16'h5A5A);
    bfc_host_inst.wr(19'h00000, 16'h0030);
    chk(busy_n, 1'b0);
    idle();
    bfc_host_inst.rd(19'h03020, d);
    chk(d, 16'hFFFF);
    bfc_host_inst.rd(19'h02000, d);
    chk(d, 16'h5A5A);
  endtask
  // Burst of 33 advances wraps back to the group start
  task automatic t_burst();
    ul(19'h00555, 16'h00C0);
    bfc_host_inst.burst(19'h0201F, 33, d);
    chk(d, 16'h5A5A);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    t_prog();
    t_prot();
    t_hwrst();
    t_erase();
    t_burst();
    report_and_stop();
  end
endmodule
